/* File: rtl/adc_scan_consts.vh */
/*
 * Scan sequencer constants: offsets, fields, reset values, codes, widths.
 * Assumes byte addresses, one 32-bit word a register.
 */
`ifndef ADC_SCAN_CONSTS_VH
`define ADC_SCAN_CONSTS_VH

// ==========================================================
// Widths
`define ADDR_W        8
`define DATA_W        32
`define RES_W         12
`define CH_W          3
`define SLOT_W        3
`define SLOTS         8
`define LIST_W        24
`define EV_W          4

// ==========================================================
// Register offsets
`define OFF_CTRL      8'h00
`define OFF_STAT      8'h04
`define OFF_MASK      8'h08
`define OFF_LIST      8'h0C
`define OFF_LOLIM     8'h10
`define OFF_HILIM     8'h14
`define OFF_ZC        8'h18
`define RES_PAGE      3'h1

// ==========================================================
// Control fields
`define CTRL_MODE     1:0
`define CTRL_SIMUL    2
`define CTRL_LEN      6:4
`define CTRL_START    8
`define CTRL_STOP     9

// Scan modes
`define MODE_ONCE     2'h0
`define MODE_TRIG     2'h1
`define MODE_LOOP     2'h2

// ==========================================================
// Status and mask fields
`define EV_EOS        0
`define EV_LO         1
`define EV_HI         2
`define EV_ZC         3
`define STAT_BUSY     8
`define STAT_ARMED    9
`define STAT_LOOP     10

// Zero-crossing fields and modes
`define ZC_MODE       1:0
`define ZC_OFFSET     27:16
`define ZC_OFF        2'h0
`define ZC_FALL       2'h1
`define ZC_RISE       2'h2
`define ZC_ANY        2'h3

// ==========================================================
// Reset values
`define RST_LIST      24'hFAC688
`define RST_LOLIM     12'h000
`define RST_HILIM     12'hFFF
`define RST_OFFSET    12'h800

`endif

/* File: rtl/scan_result_mem.v */
/*
 * Result store, one word a slot, and the registered read port.
 * Assumes at most one write and one read a cycle.
 */
`timescale 1ns/1ps
`include "adc_scan_consts.vh"

module scan_result_mem #(
    parameter SLOTS  = `SLOTS,
    parameter RES_W  = `RES_W,
    parameter SLOT_W = `SLOT_W
) (
    input  wire                clk_sys,
    input  wire                resetn,
    input  wire                wr_en,
    input  wire [SLOT_W-1:0]   wr_slot,
    input  wire [RES_W-1:0]    wr_data,
    input  wire                rd_en,
    input  wire                rd_res,
    input  wire [SLOT_W-1:0]   rd_slot,
    input  wire [`DATA_W-1:0]  rd_other,
    output reg  [`DATA_W-1:0]  rd_q_r
);

    wire [RES_W-1:0] word_w [0:SLOTS-1];

    // ==========================================================
    // Storage words
    genvar i;
    generate
        for (i = 0; i < SLOTS; i = i + 1) begin : g_word
            reg [RES_W-1:0] word_r;
            // Cleared at reset so an early read is defined
            always @(posedge clk_sys) begin
                if (!resetn)
                    word_r <= {RES_W{1'b0}};
                else if (wr_en && (wr_slot == i))
                    word_r <= wr_data;
            end
            assign word_w[i] = word_r;
        end
    endgenerate

    // ==========================================================
    // Read port: data stand only in the cycle after the strobe
    always @(posedge clk_sys) begin
        if (!resetn)
            rd_q_r <= {`DATA_W{1'b0}};
        else if (rd_en && rd_res)
            rd_q_r <= {{(`DATA_W-RES_W){1'b0}}, word_w[rd_slot]};
        else if (rd_en)
            rd_q_r <= rd_other;
        else
            rd_q_r <= {`DATA_W{1'b0}};
    end

endmodule

/* File: rtl/scan_limit_check.v */
/*
 * Per-result limit and zero-crossing checks, judged on each store.
 * Assumes one store a cycle; hit pulses follow one cycle later.
 */
`timescale 1ns/1ps
`include "adc_scan_consts.vh"

module scan_limit_check #(
    parameter SLOTS  = `SLOTS,
    parameter RES_W  = `RES_W,
    parameter SLOT_W = `SLOT_W
) (
    input  wire               clk_sys,
    input  wire               resetn,
    input  wire               chk_en,
    input  wire [SLOT_W-1:0]  chk_slot,
    input  wire [RES_W-1:0]   chk_data,
    input  wire [RES_W-1:0]   lo_lim,
    input  wire [RES_W-1:0]   hi_lim,
    input  wire [RES_W-1:0]   zc_offset,
    input  wire [1:0]         zc_mode,
    output reg                lo_hit_r,
    output reg                hi_hit_r,
    output reg                zc_hit_r
);

    wire [SLOTS-1:0] prev_pos_w;
    wire [SLOTS-1:0] seen_w;
    wire             pos_w  = (chk_data >= zc_offset);
    wire             prev_w = prev_pos_w[chk_slot];
    wire             seen   = seen_w[chk_slot];
    reg              zc_nxt;

    // ==========================================================
    // Last side of the offset, kept per slot
    genvar i;
    generate
        for (i = 0; i < SLOTS; i = i + 1) begin : g_side
            reg side_r;
            reg seen_r;
            always @(posedge clk_sys) begin
                if (!resetn) begin
                    side_r <= 1'b0;
                    seen_r <= 1'b0;
                end else if (chk_en && (chk_slot == i)) begin
                    side_r <= pos_w;
                    seen_r <= 1'b1;
                end
            end
            assign prev_pos_w[i] = side_r;
            assign seen_w[i]     = seen_r;
        end
    endgenerate

    // crossing decode
    // First sample of a slot has no history and never counts
    always @* begin
        case (zc_mode)
            `ZC_FALL: zc_nxt = seen & prev_w & ~pos_w;
            `ZC_RISE: zc_nxt = seen & ~prev_w & pos_w;
            `ZC_ANY:  zc_nxt = seen & (prev_w ^ pos_w);
            default:  zc_nxt = 1'b0;
        endcase
    end

    // ==========================================================
    // compare on store
    always @(posedge clk_sys) begin
        if (!resetn) begin
            lo_hit_r <= 1'b0;
            hi_hit_r <= 1'b0;
            zc_hit_r <= 1'b0;
        end else begin
            lo_hit_r <= chk_en & (chk_data < lo_lim);
            hi_hit_r <= chk_en & (chk_data > hi_lim);
            zc_hit_r <= chk_en & zc_nxt;
        end
    end

endmodule

/* File: rtl/adc_scan_sequencer.v */
/*
 * Dual-converter scan sequencer: registers, scan modes, sequential or
 * paired sampling, result store and end-of-scan events.
 * Assumes converters taking a one-cycle start and a channel, answering
 * with a one-cycle done and a 12-bit result.
 */
// Added by the designer: the address-and-strobe port and the placing of the registers.
// Behaviour
// - Three modes: single scan then halt, scan per trigger, loop until stopped.
// - Control bit selects sequential or paired simultaneous conversion.
// - Sequential scan takes up to eight slots in channel-list order.
// - In sequential mode channels 4 to 7 use converter B, so one scan can use both.
// - Simultaneous mode starts both sample paths in the same cycle for each slot pair; an odd last slot starts converter A alone.
// - End of scan flags results below low or above high limit.
// - End of scan flags selectable zero crossings of the results.
`timescale 1ns/1ps
`include "adc_scan_consts.vh"

module adc_scan_sequencer (
    input  wire                 clk_sys,
    input  wire                 resetn,
    input  wire [`ADDR_W-1:0]   bus_addr,
    input  wire [`DATA_W-1:0]   bus_wdata,
    input  wire                 bus_wr,
    input  wire                 bus_rd,
    output wire [`DATA_W-1:0]   bus_rdata,
    input  wire                 scan_trig,
    output reg                  conv_start_a,
    output reg  [`CH_W-1:0]     conv_chan_a,
    input  wire                 conv_done_a,
    input  wire [`RES_W-1:0]    conv_data_a,
    output reg                  conv_start_b,
    output reg  [`CH_W-1:0]     conv_chan_b,
    input  wire                 conv_done_b,
    input  wire [`RES_W-1:0]    conv_data_b,
    output reg                  scan_busy,
    output reg                  irq
);

    // ==========================================================
    // States, one-hot
    localparam [5:0] ST_IDLE  = 6'h01;
    localparam [5:0] ST_ISSUE = 6'h02;
    localparam [5:0] ST_WAIT  = 6'h04;
    localparam [5:0] ST_STA   = 6'h08;
    localparam [5:0] ST_STB   = 6'h10;
    localparam [5:0] ST_EOS   = 6'h20;

    // Channel of a list slot
    function [`CH_W-1:0] chan_of;
        input [`LIST_W-1:0] lst;
        input [`SLOT_W-1:0] idx;
        begin
            chan_of = lst[({2'b00, idx} + {1'b0, idx, 1'b0}) +: `CH_W];
        end
    endfunction

    // ==========================================================
    // Registers
    reg  [1:0]          mode_r;
    reg                 simul_r;
    reg  [2:0]          len_r;
    reg  [`LIST_W-1:0]  list_r;
    reg  [`RES_W-1:0]   lolim_r;
    reg  [`RES_W-1:0]   hilim_r;
    reg  [1:0]          zc_mode_r;
    reg  [`RES_W-1:0]   offset_r;
    reg  [`EV_W-1:0]    mask_r;
    reg  [`EV_W-1:0]    sts_r;
    reg  [`EV_W-1:0]    sts_nxt;
    reg                 armed_r;
    reg                 loop_r;
    reg  [5:0]          state_r;
    reg  [`SLOT_W-1:0]  idx_r;
    reg  [`SLOT_W-1:0]  slot_a_r;
    reg  [`SLOT_W-1:0]  slot_b_r;
    reg                 need_a_r;
    reg                 need_b_r;
    reg                 got_a_r;
    reg                 got_b_r;
    reg  [`RES_W-1:0]   hold_a_r;
    reg  [`RES_W-1:0]   hold_b_r;
    reg  [2:0]          pend_r;
    reg                 mem_we;
    reg  [`SLOT_W-1:0]  mem_slot;
    reg  [`RES_W-1:0]   mem_data;
    reg  [`DATA_W-1:0]  rd_other;

    wire                lo_hit;
    wire                hi_hit;
    wire                zc_hit;

    // ==========================================================
    // Bus decode
    wire wr_ctrl  = bus_wr && (bus_addr == `OFF_CTRL);
    wire wr_stat  = bus_wr && (bus_addr == `OFF_STAT);
    wire start_wr = wr_ctrl && bus_wdata[`CTRL_START];
    wire stop_wr  = wr_ctrl && bus_wdata[`CTRL_STOP];
    wire rd_res   = (bus_addr[7:5] == `RES_PAGE) && (bus_addr[1:0] == 2'h0);
    wire [1:0] new_mode = bus_wdata[`CTRL_MODE];

    // scan launch
    // Start in triggered mode only arms; a trigger then runs a scan only if it comes in ST_IDLE
    wire go_scan = (start_wr && (new_mode != `MODE_TRIG)) ||
                   (armed_r && scan_trig && !stop_wr);

    // Pair and slot arithmetic
    wire [`SLOT_W-1:0] idx_p1  = idx_r + 3'h1;
    wire               has_pair = (idx_r < len_r);
    wire [`CH_W-1:0]   ch_first = chan_of(list_r, idx_r);
    wire [`CH_W-1:0]   ch_pair  = chan_of(list_r, idx_p1);
    wire               step_two = simul_r && has_pair;
    wire               last_pos = step_two ? (idx_p1 >= len_r) : (idx_r >= len_r);
    wire               all_got  = (got_a_r || !need_a_r) && (got_b_r || !need_b_r);

    // ==========================================================
    // Configuration registers
    always @(posedge clk_sys) begin
        if (!resetn) begin
            mode_r    <= `MODE_ONCE;
            simul_r   <= 1'b0;
            len_r     <= 3'h7;
            list_r    <= `RST_LIST;
            lolim_r   <= `RST_LOLIM;
            hilim_r   <= `RST_HILIM;
            zc_mode_r <= `ZC_OFF;
            offset_r  <= `RST_OFFSET;
            mask_r    <= {`EV_W{1'b0}};
        end else if (bus_wr) begin
            case (bus_addr)
                `OFF_CTRL: begin
                    mode_r  <= new_mode;
                    simul_r <= bus_wdata[`CTRL_SIMUL];
                    len_r   <= bus_wdata[`CTRL_LEN];
                end
                `OFF_MASK:  mask_r  <= bus_wdata[`EV_W-1:0];
                `OFF_LIST:  list_r  <= bus_wdata[`LIST_W-1:0];
                `OFF_LOLIM: lolim_r <= bus_wdata[`RES_W-1:0];
                `OFF_HILIM: hilim_r <= bus_wdata[`RES_W-1:0];
                `OFF_ZC: begin
                    zc_mode_r <= bus_wdata[`ZC_MODE];
                    offset_r  <= bus_wdata[`ZC_OFFSET];
                end
                default: ;
            endcase
        end
    end

    // ==========================================================
    // sticky events
    // A set in the same cycle as a write-one clear wins
    always @* begin
        sts_nxt = sts_r & ~(wr_stat ? bus_wdata[`EV_W-1:0] : {`EV_W{1'b0}});
        if (state_r == ST_EOS) begin
            sts_nxt[`EV_EOS] = 1'b1;
            sts_nxt[`EV_LO] = sts_nxt[`EV_LO] | pend_r[0] | lo_hit;
            sts_nxt[`EV_HI] = sts_nxt[`EV_HI] | pend_r[1] | hi_hit;
            sts_nxt[`EV_ZC] = sts_nxt[`EV_ZC] | pend_r[2] | zc_hit;
        end
    end

    // masked interrupt
    // Registered from the next status, so it moves with it
    always @(posedge clk_sys) begin
        if (!resetn) begin
            sts_r <= {`EV_W{1'b0}};
            irq   <= 1'b0;
        end else begin
            sts_r <= sts_nxt;
            irq   <= |(sts_nxt & mask_r);
        end
    end

    // ==========================================================
    // Scan state machine
    always @(posedge clk_sys) begin
        if (!resetn) begin
            state_r      <= ST_IDLE;
            armed_r      <= 1'b0;
            loop_r       <= 1'b0;
            idx_r        <= {`SLOT_W{1'b0}};
            slot_a_r     <= {`SLOT_W{1'b0}};
            slot_b_r     <= {`SLOT_W{1'b0}};
            need_a_r     <= 1'b0;
            need_b_r     <= 1'b0;
            got_a_r      <= 1'b0;
            got_b_r      <= 1'b0;
            hold_a_r     <= {`RES_W{1'b0}};
            hold_b_r     <= {`RES_W{1'b0}};
            pend_r       <= 3'h0;
            conv_start_a <= 1'b0;
            conv_start_b <= 1'b0;
            conv_chan_a  <= {`CH_W{1'b0}};
            conv_chan_b  <= {`CH_W{1'b0}};
            scan_busy    <= 1'b0;
        end else begin
            conv_start_a <= 1'b0;
            conv_start_b <= 1'b0;
            if (stop_wr) begin
                armed_r <= 1'b0;
                loop_r  <= 1'b0;
            end else if (start_wr) begin
                armed_r <= (new_mode == `MODE_TRIG);
                loop_r  <= (new_mode == `MODE_LOOP);
            end
            // Late results are caught in every state but ST_ISSUE, which clears the got flags
            if (conv_done_a) begin
                got_a_r  <= 1'b1;
                hold_a_r <= conv_data_a;
            end
            if (conv_done_b) begin
                got_b_r  <= 1'b1;
                hold_b_r <= conv_data_b;
            end
            // Hit pulses lag the store by one cycle
            pend_r <= pend_r | {zc_hit, hi_hit, lo_hit};
            case (state_r)
                ST_IDLE: begin
                    if (go_scan) begin
                        state_r   <= ST_ISSUE;
                        idx_r     <= {`SLOT_W{1'b0}};
                        pend_r    <= 3'h0;
                        scan_busy <= 1'b1;
                    end
                end
                ST_ISSUE: begin
                    got_a_r  <= 1'b0;
                    got_b_r  <= 1'b0;
                    slot_a_r <= idx_r;
                    state_r  <= ST_WAIT;
                    if (simul_r) begin
                        conv_start_a <= 1'b1;
                        conv_chan_a  <= ch_first;
                        need_a_r     <= 1'b1;
                        conv_start_b <= has_pair;
                        conv_chan_b  <= ch_pair;
                        need_b_r     <= has_pair;
                        slot_b_r     <= idx_p1;
                    end else begin
                        conv_start_a <= ~ch_first[`CH_W-1];
                        conv_start_b <= ch_first[`CH_W-1];
                        conv_chan_a  <= ch_first;
                        conv_chan_b  <= ch_first;
                        need_a_r     <= ~ch_first[`CH_W-1];
                        need_b_r     <= ch_first[`CH_W-1];
                        slot_b_r     <= idx_r;
                    end
                end
                ST_WAIT: begin
                    if (all_got)
                        state_r <= ST_STA;
                end
                ST_STA: state_r <= ST_STB;
                ST_STB: begin
                    idx_r   <= step_two ? (idx_r + 3'h2) : idx_p1;
                    state_r <= last_pos ? ST_EOS : ST_ISSUE;
                end
                ST_EOS: begin
                    pend_r <= 3'h0;
                    if (loop_r && !stop_wr) begin
                        state_r <= ST_ISSUE;
                        idx_r   <= {`SLOT_W{1'b0}};
                    end else begin
                        state_r   <= ST_IDLE;
                        scan_busy <= 1'b0;
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // ==========================================================
    // store path
    // One write port: paired results go in over two cycles
    always @* begin
        mem_we   = 1'b0;
        mem_slot = slot_a_r;
        mem_data = hold_a_r;
        if (state_r == ST_STA) begin
            mem_we = need_a_r;
        end else if (state_r == ST_STB) begin
            mem_we   = need_b_r;
            mem_slot = slot_b_r;
            mem_data = hold_b_r;
        end
    end

    // Read view of the non-result registers
    always @* begin
        case (bus_addr)
            `OFF_CTRL:  rd_other = {25'h0000000, len_r, 1'b0, simul_r, mode_r};
            `OFF_STAT:  rd_other = {21'h000000, loop_r, armed_r, scan_busy,
                                    4'h0, sts_r};
            `OFF_MASK:  rd_other = {28'h0000000, mask_r};
            `OFF_LIST:  rd_other = {8'h00, list_r};
            `OFF_LOLIM: rd_other = {20'h00000, lolim_r};
            `OFF_HILIM: rd_other = {20'h00000, hilim_r};
            `OFF_ZC:    rd_other = {4'h0, offset_r, 14'h0000, zc_mode_r};
            default:    rd_other = {`DATA_W{1'b0}};
        endcase
    end

    // ==========================================================
    // Result store and register read port
    scan_result_mem u_mem (
        .clk_sys  (clk_sys),
        .resetn   (resetn),
        .wr_en    (mem_we),
        .wr_slot  (mem_slot),
        .wr_data  (mem_data),
        .rd_en    (bus_rd),
        .rd_res   (rd_res),
        .rd_slot  (bus_addr[4:2]),
        .rd_other (rd_other),
        .rd_q_r   (bus_rdata)
    );

    // Limit and crossing checks
    scan_limit_check u_chk (
        .clk_sys   (clk_sys),
        .resetn    (resetn),
        .chk_en    (mem_we),
        .chk_slot  (mem_slot),
        .chk_data  (mem_data),
        .lo_lim    (lolim_r),
        .hi_lim    (hilim_r),
        .zc_offset (offset_r),
        .zc_mode   (zc_mode_r),
        .lo_hit_r  (lo_hit),
        .hi_hit_r  (hi_hit),
        .zc_hit_r  (zc_hit)
    );

endmodule

/* File: tb/adc_scan_monitor.sv */
/*
 * Port checker for the scan sequencer, bound to its top module.
 * Assumes one clock domain and a synchronous active-low reset.
 */
`timescale 1ns/1ps
`include "adc_scan_consts.vh"

module adc_scan_monitor (
    input wire               clk_sys,
    input wire               resetn,
    input wire [`ADDR_W-1:0] bus_addr,
    input wire [`DATA_W-1:0] bus_wdata,
    input wire               bus_wr,
    input wire               bus_rd,
    input wire [`DATA_W-1:0] bus_rdata,
    input wire               scan_trig,
    input wire               conv_start_a,
    input wire [`CH_W-1:0]   conv_chan_a,
    input wire               conv_done_a,
    input wire [`RES_W-1:0]  conv_data_a,
    input wire               conv_start_b,
    input wire [`CH_W-1:0]   conv_chan_b,
    input wire               conv_done_b,
    input wire [`RES_W-1:0]  conv_data_b,
    input wire               scan_busy,
    input wire               irq
);
    // ==========================================================
    // One domain, so defaults keep properties short
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    // ==========================================================
    // Assertions
    reset_quiet_a: assert property (disable iff (1'b0) !resetn |=>
        !scan_busy && !irq && !conv_start_a && !conv_start_b && bus_rdata == 32'h0)
        else $error("outputs not quiet in reset");
    rdata_idle_a: assert property (!$past(bus_rd) |-> bus_rdata == 32'h0)
        else $error("read data outside its slot");
    start_pulse_a: assert property (conv_start_a || conv_start_b |=>
        !conv_start_a && !conv_start_b) else $error("start longer than one cycle");
    start_busy_a: assert property (conv_start_a || conv_start_b |-> scan_busy)
        else $error("start outside a scan");
    busy_launch_a: assert property ($rose(scan_busy) |=> conv_start_a || conv_start_b)
        else $error("scan launch without start");
    busy_cause_a: assert property ($rose(scan_busy) |->
        $past(bus_wr) || $past(scan_trig))
        else $error("scan without write or trigger");
    done_gap_a: assert property (conv_done_a || conv_done_b |->
        (!conv_start_a && !conv_start_b) [*4]) else $error("start too soon after done");
    chan_hold_a: assert property (!conv_start_a && !conv_start_b |->
        $stable(conv_chan_a) && $stable(conv_chan_b)) else $error("channel moved");
    irq_clear_a: assert property ($fell(irq) |->
        $past(bus_wr) || $past(bus_wr, 2)) else $error("interrupt dropped by itself");

    // Main scenarios reached
    scan_end_c: cover property ($fell(scan_busy));
    pair_start_c: cover property (conv_start_a && conv_start_b);
    irq_raise_c: cover property ($rose(irq));
endmodule

bind adc_scan_sequencer adc_scan_monitor adc_scan_monitor_i (
    .clk_sys(clk_sys), .resetn(resetn), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .scan_trig(scan_trig),
    .conv_start_a(conv_start_a), .conv_chan_a(conv_chan_a), .conv_done_a(conv_done_a),
    .conv_data_a(conv_data_a), .conv_start_b(conv_start_b), .conv_chan_b(conv_chan_b),
    .conv_done_b(conv_done_b), .conv_data_b(conv_data_b), .scan_busy(scan_busy),
    .irq(irq));

/* File: tb/tb_adc_scan_sequencer.sv */
/*
 * Bench for the scan sequencer: register tasks, converter responder, scenarios.
 * Assumes the port checker binds itself to the design.
 */
`timescale 1ns/1ps
`include "adc_scan_consts.vh"
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin fails++; \
    $display("unexpected %s exp %h got %h", n, e, g); end end

module tb_adc_scan_sequencer;
    logic        clk_sys = 0, resetn = 0, bus_wr = 0, bus_rd = 0, scan_trig = 0, sim = 0;
    logic [7:0]  bus_addr = 8'h00, pv = 8'h00, ps = 8'h00;
    logic [31:0] bus_wdata = 32'h0, rd_v;
    logic [11:0] v, exp_q [$];
    logic [11:0] dat [2] = '{12'h0, 12'h0};
    logic [2:0]  cnt [2] = '{3'h0, 3'h0};
    logic [2:0]  chan_q [$];
    logic [1:0]  dn = 2'h0;
    int          fails = 0, total_checks = 0, cyc = 0;
    wire [31:0]  bus_rdata;
    wire [2:0]   conv_chan_a, conv_chan_b;
    wire         conv_start_a, conv_start_b, scan_busy, irq;
    // Idle data lines show the inverse, so stale data never match
    wire [11:0]  conv_data_a = dn[0] ? dat[0] : ~dat[0];
    wire [11:0]  conv_data_b = dn[1] ? dat[1] : ~dat[1];

    adc_scan_sequencer adc_scan_sequencer_i (.clk_sys(clk_sys), .resetn(resetn),
        .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
        .bus_rdata(bus_rdata), .scan_trig(scan_trig), .conv_start_a(conv_start_a),
        .conv_chan_a(conv_chan_a), .conv_done_a(dn[0]), .conv_data_a(conv_data_a),
        .conv_start_b(conv_start_b), .conv_chan_b(conv_chan_b), .conv_done_b(dn[1]),
        .conv_data_b(conv_data_b), .scan_busy(scan_busy), .irq(irq));

    // ==========================================================
    // Clock, hang limit, converter responder
    always #5 clk_sys = ~clk_sys;

    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fails++;
            give_verdict();
        end
    end

    // Latency 1..4; logged in start order, A before B
    always @(posedge clk_sys) begin
        for (int k = 0; k < 2; k++) begin
            dn[k] <= (cnt[k] == 3'h1);
            if (cnt[k] != 3'h0) cnt[k] <= cnt[k] - 3'h1;
            if (k ? conv_start_b : conv_start_a) begin
                v = 12'($urandom);
                dat[k] <= v;
                cnt[k] <= 3'h1 + 3'($urandom % 4);
                exp_q.push_back(v);
                chan_q.push_back(k ? conv_chan_b : conv_chan_a);
                if (!sim) `CHK("route", k ? 1'b1 : 1'b0, k ? conv_chan_b[2] : conv_chan_a[2])
                if (!sim && k) `CHK("seq_single", 1'b0, conv_start_a)
            end
        end
    end

    // ==========================================================
    // Register port tasks
    task wr(input logic [7:0] a, input logic [31:0] d);
        bus_addr <= a;
        bus_wdata <= d;
        bus_wr <= 1'b1;
        @(posedge clk_sys);
        bus_wr <= 1'b0;
        @(posedge clk_sys);
    endtask

    task rchk(input string n, input logic [7:0] a, input logic [31:0] e);
        bus_addr <= a;
        bus_rd <= 1'b1;
        @(posedge clk_sys);
        bus_rd <= 1'b0;
        #1 rd_v = bus_rdata;
        `CHK(n, e, rd_v)
        @(posedge clk_sys);
    endtask

    task idle();
        for (int n = 0; n < 400 && scan_busy; n++) begin
            @(posedge clk_sys);
            #1;
        end
        `CHK("busy_end", 1'b0, scan_busy)
        @(posedge clk_sys);
    endtask

    task give_verdict();
        if (fails == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // ==========================================================
    // One scan with random list, limits and offset
    task run_scan(input logic [1:0] md, input logic sm, input logic [2:0] ln,
                  input logic [1:0] zm, input logic [3:0] mk);
        logic [23:0] lst;
        logic [11:0] lo, hi, off, d;
        logic [3:0]  ev;
        logic        s_now;
        lst = 24'($urandom);
        for (int i = 0; i < 8; i += 2) lst[3*i+3 +: 3] = lst[3*i +: 3] ^ (3'h1 + 3'($urandom % 7));
        lo = 12'($urandom % 2048);
        hi = 12'h800 + 12'($urandom % 2048);
        off = 12'($urandom);
        sim = sm;
        wr(`OFF_LIST, {8'h0, lst});
        wr(`OFF_LOLIM, {20'h0, lo});
        wr(`OFF_HILIM, {20'h0, hi});
        wr(`OFF_ZC, {4'h0, off, 14'h0, zm});
        wr(`OFF_MASK, {28'h0, mk});
        exp_q.delete();
        chan_q.delete();
        wr(`OFF_CTRL, {23'h0, 1'b1, 1'b0, ln, 1'b0, sm, md});
        if (md == `MODE_TRIG) begin
            `CHK("armed_wait", 1'b0, scan_busy)
            scan_trig <= 1'b1;
            @(posedge clk_sys);
            scan_trig <= 1'b0;
            repeat (2) @(posedge clk_sys);
            `CHK("trig_run", 1'b1, scan_busy)
        end
        idle();
        ev = 4'h1;
        `CHK("starts", 32'(ln) + 1, chan_q.size())
        for (int i = 0; i <= ln; i++) begin
            d = exp_q[i];
            `CHK("chan", lst[3*i +: 3], chan_q[i])
            rchk("result", 8'h20 + 8'(4 * i), {20'h0, d});
            ev[1] = ev[1] | (d < lo);
            ev[2] = ev[2] | (d > hi);
            s_now = (d >= off);
            if (pv[i] && zm != 2'h0 && s_now != ps[i] && (zm == 2'h3 || s_now == (zm == 2'h2)))
                ev[3] = 1'b1;
            ps[i] = s_now;
            pv[i] = 1'b1;
        end
        rchk("status", `OFF_STAT, {21'h0, 1'b0, md == `MODE_TRIG, 1'b0, 4'h0, ev});
        `CHK("irq", |(ev & mk), irq)
        wr(`OFF_STAT, 32'hF);
        #1 `CHK("irq_clear", 1'b0, irq)
        @(posedge clk_sys);
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        void'($urandom(32'h98fc));
        repeat (8) @(posedge clk_sys);
        resetn <= 1'b1;
        @(posedge clk_sys);
        rchk("list_rst", `OFF_LIST, {8'h0, `RST_LIST});
        rchk("hilim_rst", `OFF_HILIM, {20'h0, `RST_HILIM});
        rchk("zc_rst", `OFF_ZC, {4'h0, `RST_OFFSET, 16'h0});
        rchk("mask_rst", `OFF_MASK, 32'h0);
        wr(8'h1C, 32'hFFFFFFFF);
        wr(8'h20, 32'hABC);
        rchk("unmapped", 8'h1C, 32'h0);
        rchk("result_ro", 8'h20, 32'h0);
        for (int s = 0; s < 8; s++)
            run_scan(`MODE_ONCE, s[1], 3'(s * 3), 2'(s), s == 0 ? 4'h0 : 4'(1 | $urandom));
        run_scan(`MODE_TRIG, 1'b0, 3'h2, `ZC_OFF, 4'hF);
        wr(`OFF_LOLIM, 0);
        wr(`OFF_HILIM, 12'hFFF);
        chan_q.delete();
        wr(`OFF_CTRL, {23'h0, 1'b1, 1'b0, 3'h1, 2'h0, `MODE_LOOP});
        repeat (60) @(posedge clk_sys);
        rchk("loop_bit", `OFF_STAT, 32'h501);
        wr(`OFF_CTRL, 32'h212);
        idle();
        `CHK("loop_whole", 0, chan_q.size() % 2)
        `CHK("loop_many", 1'b1, chan_q.size() > 2)
        give_verdict();
    end
endmodule
